// [led_output_drive_pwm_mixer.sv]
// led output stage: pwm generators, group mixer, transistor drive, axi4-lite registers
// How it works
// - gate low, off/on states drive hi-z, high or low per invert and totem-pole.
// - individual state drives low side by channel duty, high side complementary in totem.
// - combined state gates channel duty with group signal, same invert and totem handling.
// - totem-pole clear never turns the high-side transistor on.
// - gate pin high overrides state and invert settings with disabled field; totem still gates the high side for 01.
// - individual pwm runs near 97 kHz with 256 steps from 8-bit duty.
// - group dimming is a shared 190 Hz pwm from the 8-bit group duty.
// - group blinking period is 8-bit programmable from 24 Hz down to about 10.7 s.
// - disabled field 00 low, 01 high or hi-z, 10 hi-z, 11 reserved.
// - group blink select picks blinking generator when set, dimming when clear.
//
// The AXI4-Lite register port and the register offsets were decided locally.
`default_nettype none
module led_output_drive_pwm_mixer
  import led_drive_pkg::*;
#(
  parameter int NUM_CH = NUM_CH_DEF,
  parameter int BLINK_TICK_CYC = BLINK_TICK_CYC_DEF
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic output_gate_n,
  output logic [NUM_CH-1:0] upper_on,
  output logic [NUM_CH-1:0] lower_on
);
  localparam int IDX_W = $clog2(NUM_CH);
  localparam int BT_W = $clog2(BLINK_TICK_CYC);

  if (NUM_CH != NUM_CH_DEF || BLINK_TICK_CYC < 2 || IND_STEP_CYC < 1) begin : g_bad
    $error("unsupported channel count or blink tick length");
  end

  // {upper, lower} for one channel
  function automatic logic [1:0] drive_of(input logic gate, input logic [1:0] st,
      input logic pwm, input logic grp, input logic inv, input logic drv,
      input logic [1:0] dis);
    logic act;
    logic level;
    act = 1'b0;
    level = 1'b0;
    if (gate) begin
      case (dis)
        DIS_LOW: drive_of = 2'b01;
        DIS_HIGH: drive_of = {drv, 1'b0};
        default: drive_of = 2'b00;
      endcase
    end else begin
      case (st)
        STATE_OFF: act = 1'b0;
        STATE_ON: act = 1'b1;
        STATE_IND: act = pwm;
        default: act = pwm & grp;
      endcase
      // active led pulls the pin low unless inverted
      level = inv ? act : ~act;
      drive_of = {level & drv, ~level};
    end
  endfunction : drive_of

  function automatic logic is_duty(input logic [ADDR_W-1:0] a);
    is_duty = (a[ADDR_W-1:6] == DUTY_BASE_TAG);
  endfunction : is_duty

  // shared group signal, read by the status register and the mixer
  logic group_sig;

  // gate pin synchroniser
  logic gate_meta_reg;
  logic gate_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      gate_meta_reg <= 1'b1;
      gate_reg <= 1'b1;
    end else begin
      gate_meta_reg <= output_gate_n;
      gate_reg <= gate_meta_reg;
    end
  end

  // write channel
  logic aw_held_reg;
  logic w_held_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_fire;
  assign s_axi_awready = ~aw_held_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held_reg & ~s_axi_bvalid;
  assign wr_fire = aw_held_reg & w_held_reg & ~s_axi_bvalid;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      waddr_reg <= '0;
      wdata_reg <= '0;
      wstrb_reg <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        waddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (is_duty(waddr_reg) || waddr_reg == ADDR_MODE
            || waddr_reg == ADDR_GROUP_DUTY || waddr_reg == ADDR_GROUP_PERIOD
            || waddr_reg == ADDR_CHANNEL_STATE || waddr_reg == ADDR_STATUS)
            ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control registers
  logic [4:0] mode_reg;
  logic [7:0] group_duty_reg;
  logic [7:0] group_period_reg;
  logic [2*NUM_CH-1:0] state_reg;
  logic wr_low;
  assign wr_low = wr_fire & wstrb_reg[0];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      mode_reg <= MODE_RESET;
      group_duty_reg <= GROUP_DUTY_RESET;
      group_period_reg <= GROUP_PERIOD_RESET;
    end else if (wr_low) begin
      if (waddr_reg == ADDR_MODE) mode_reg <= wdata_reg[4:0];
      if (waddr_reg == ADDR_GROUP_DUTY) group_duty_reg <= wdata_reg[7:0];
      if (waddr_reg == ADDR_GROUP_PERIOD) group_period_reg <= wdata_reg[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_reg <= '0;
    end else if (wr_fire && waddr_reg == ADDR_CHANNEL_STATE) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_reg[b]) state_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
      end
    end
  end

  logic blink_sel;
  logic inv;
  logic drv;
  logic [1:0] dis;
  assign blink_sel = mode_reg[MODE_BLINK_BIT];
  assign inv = mode_reg[MODE_INVERT_BIT];
  assign drv = mode_reg[MODE_TOTEM_BIT];
  assign dis = mode_reg[MODE_DIS_LSB +: 2];

  // duty store
  logic [DUTY_W-1:0] mem_rdata;
  logic [DUTY_W*NUM_CH-1:0] duty_all;
  led_duty_store #(.WIDTH(DUTY_W), .DEPTH(NUM_CH)) u_store (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wr_en(wr_low & is_duty(waddr_reg)),
    .wr_addr(waddr_reg[2 +: IDX_W]),
    .wr_data(wdata_reg[DUTY_W-1:0]),
    .rd_addr(s_axi_araddr[2 +: IDX_W]),
    .rd_data(mem_rdata),
    .all_data(duty_all)
  );

  // read channel: accept, fetch, answer
  logic rd_busy_reg;
  logic rd_fetch_reg;
  logic [ADDR_W-1:0] raddr_reg;
  assign s_axi_arready = ~rd_busy_reg;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_busy_reg <= 1'b0;
      rd_fetch_reg <= 1'b0;
      raddr_reg <= '0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_busy_reg <= 1'b1;
      rd_fetch_reg <= 1'b1;
      raddr_reg <= s_axi_araddr;
    end else if (rd_fetch_reg) begin
      rd_fetch_reg <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      if (is_duty(raddr_reg)) s_axi_rdata <= {24'h000000, mem_rdata};
      else if (raddr_reg == ADDR_MODE) s_axi_rdata <= {27'h0, mode_reg};
      else if (raddr_reg == ADDR_GROUP_DUTY) s_axi_rdata <= {24'h000000, group_duty_reg};
      else if (raddr_reg == ADDR_GROUP_PERIOD) s_axi_rdata <= {24'h000000, group_period_reg};
      else if (raddr_reg == ADDR_CHANNEL_STATE) s_axi_rdata <= state_reg;
      else if (raddr_reg == ADDR_STATUS) s_axi_rdata <= {30'h0, group_sig, gate_reg};
      else begin
        s_axi_rdata <= '0;
        s_axi_rresp <= RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      rd_busy_reg <= 1'b0;
    end
  end

  // individual pwm timebase
  logic [$clog2(IND_STEP_CYC+1)-1:0] ind_div_reg;
  logic [DUTY_W-1:0] ind_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ind_div_reg <= '0;
      ind_cnt_reg <= '0;
    end else if (ind_div_reg == ($bits(ind_div_reg))'(IND_STEP_CYC - 1)) begin
      ind_div_reg <= '0;
      ind_cnt_reg <= ind_cnt_reg + 8'h01;
    end else begin
      ind_div_reg <= ind_div_reg + 1'b1;
    end
  end

  // group dimming timebase
  logic [$clog2(DIM_STEP_CYC)-1:0] dim_div_reg;
  logic [DUTY_W-1:0] dim_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      dim_div_reg <= '0;
      dim_cnt_reg <= '0;
    end else if (dim_div_reg == ($bits(dim_div_reg))'(DIM_STEP_CYC - 1)) begin
      dim_div_reg <= '0;
      dim_cnt_reg <= dim_cnt_reg + 8'h01;
    end else begin
      dim_div_reg <= dim_div_reg + 1'b1;
    end
  end

  // group blinking timebase: period register stretches each step
  logic [BT_W-1:0] blink_div_reg;
  logic [7:0] blink_sub_reg;
  logic [DUTY_W-1:0] blink_cnt_reg;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      blink_div_reg <= '0;
      blink_sub_reg <= '0;
      blink_cnt_reg <= '0;
    end else if (blink_div_reg == BT_W'(BLINK_TICK_CYC - 1)) begin
      blink_div_reg <= '0;
      if (blink_sub_reg >= group_period_reg) begin
        blink_sub_reg <= '0;
        blink_cnt_reg <= blink_cnt_reg + 8'h01;
      end else begin
        blink_sub_reg <= blink_sub_reg + 8'h01;
      end
    end else begin
      blink_div_reg <= blink_div_reg + 1'b1;
    end
  end

  logic [NUM_CH-1:0] pwm_ind;
  always_comb begin
    group_sig = blink_sel ? (blink_cnt_reg < group_duty_reg)
                          : (dim_cnt_reg < group_duty_reg);
    for (int c = 0; c < NUM_CH; c++) begin
      pwm_ind[c] = ind_cnt_reg < duty_all[c*DUTY_W +: DUTY_W];
    end
  end

  // transistor controls
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      upper_on <= '0;
      lower_on <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        {upper_on[c], lower_on[c]} <= drive_of(gate_reg, state_reg[2*c +: 2],
            pwm_ind[c], group_sig, inv, drv, dis);
      end
    end
  end

  logic [1:0] st0;
  assign st0 = state_reg[1:0];

  property p_off_totem;
    @(posedge clk_sys) disable iff (sys_rst)
      (!gate_reg && st0 == STATE_OFF && !inv && drv) |=> (upper_on[0] && !lower_on[0]);
  endproperty
  a_off_totem: assert property (p_off_totem) else $error("off totem not high");
  property p_on_inv_od;
    @(posedge clk_sys) disable iff (sys_rst)
      (!gate_reg && st0 == STATE_ON && inv && !drv) |=> (!upper_on[0] && !lower_on[0]);
  endproperty
  a_on_inv_od: assert property (p_on_inv_od) else $error("on inverted not hi-z");
  property p_ind_pwm;
    @(posedge clk_sys) disable iff (sys_rst)
      (!gate_reg && st0 == STATE_IND && !inv && drv)
      |=> (lower_on[0] == $past(pwm_ind[0]) && upper_on[0] == !lower_on[0]);
  endproperty
  a_ind_pwm: assert property (p_ind_pwm) else $error("individual pwm wrong");
  property p_grp_pwm;
    @(posedge clk_sys) disable iff (sys_rst)
      (!gate_reg && st0 == STATE_GRP && inv && !drv)
      |=> (lower_on[0] == !$past(pwm_ind[0] & group_sig));
  endproperty
  a_grp_pwm: assert property (p_grp_pwm) else $error("combined pwm wrong");
  property p_no_upper;
    @(posedge clk_sys) disable iff (sys_rst) !drv |=> (upper_on == '0);
  endproperty
  a_no_upper: assert property (p_no_upper) else $error("high side on in open drain");
  property p_gate_low_dis;
    @(posedge clk_sys) disable iff (sys_rst)
      (gate_reg && dis == DIS_LOW) |=> (&lower_on && upper_on == '0);
  endproperty
  a_gate_low_dis: assert property (p_gate_low_dis) else $error("disabled low wrong");
  property p_gate_hiz;
    @(posedge clk_sys) disable iff (sys_rst)
      (gate_reg && dis == DIS_HIZ) |=> (lower_on == '0 && upper_on == '0);
  endproperty
  a_gate_hiz: assert property (p_gate_hiz) else $error("disabled hi-z wrong");
  property p_duty_zero;
    @(posedge clk_sys) disable iff (sys_rst)
      (duty_all[DUTY_W-1:0] == 8'h00) |-> !pwm_ind[0];
  endproperty
  a_duty_zero: assert property (p_duty_zero) else $error("zero duty active");
  property p_ind_step;
    @(posedge clk_sys) disable iff (sys_rst)
      $changed(ind_cnt_reg) |-> ##1 $stable(ind_cnt_reg) [*1] ##1 $changed(ind_cnt_reg);
  endproperty
  a_ind_step: assert property (p_ind_step) else $error("individual step not 2 cycles");
  property p_dim_wrap;
    @(posedge clk_sys) disable iff (sys_rst)
      (dim_div_reg == ($bits(dim_div_reg))'(DIM_STEP_CYC - 1))
      |=> (dim_div_reg == '0 && dim_cnt_reg == 8'($past(dim_cnt_reg) + 8'h01));
  endproperty
  a_dim_wrap: assert property (p_dim_wrap) else $error("dimming step wrong");

  c_grp_toggle: cover property (@(posedge clk_sys) disable iff (sys_rst)
      st0 == STATE_GRP && $rose(lower_on[0]));
  c_gate_high: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(gate_reg));
  c_write: cover property (@(posedge clk_sys) disable iff (sys_rst)
      s_axi_bvalid && s_axi_bready);
  c_read: cover property (@(posedge clk_sys) disable iff (sys_rst)
      s_axi_rvalid && s_axi_rready);
endmodule : led_output_drive_pwm_mixer
`default_nettype wire

// [led_drive_pkg.sv]
// constants for the led output drive and pwm mixer
`default_nettype none
package led_drive_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int IND_PWM_HZ = 97_000;
  localparam int DIM_PWM_HZ = 190;
  localparam int BLINK_MAX_HZ = 24;
  localparam int PWM_STEPS = 256;
  // longest step that still meets the rate, so round down
  localparam int IND_STEP_CYC = CLK_HZ / (IND_PWM_HZ * PWM_STEPS);
  localparam int DIM_STEP_CYC = CLK_HZ / (DIM_PWM_HZ * PWM_STEPS);
  localparam int BLINK_TICK_CYC_DEF = CLK_HZ / (BLINK_MAX_HZ * PWM_STEPS);

  localparam int NUM_CH_DEF = 16;
  localparam int DUTY_W = 8;
  localparam int ADDR_W = 8;

  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_GROUP_DUTY = 8'h04;
  localparam logic [7:0] ADDR_GROUP_PERIOD = 8'h08;
  localparam logic [7:0] ADDR_CHANNEL_STATE = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_DUTY_BASE = 8'h40;
  localparam logic [1:0] DUTY_BASE_TAG = 2'h1;

  localparam int MODE_BLINK_BIT = 0;
  localparam int MODE_INVERT_BIT = 1;
  localparam int MODE_TOTEM_BIT = 2;
  localparam int MODE_DIS_LSB = 3;
  localparam logic [4:0] MODE_RESET = 5'h00;
  localparam logic [7:0] GROUP_DUTY_RESET = 8'hff;
  localparam logic [7:0] GROUP_PERIOD_RESET = 8'h00;

  localparam logic [1:0] STATE_OFF = 2'h0;
  localparam logic [1:0] STATE_ON = 2'h1;
  localparam logic [1:0] STATE_IND = 2'h2;
  localparam logic [1:0] STATE_GRP = 2'h3;

  localparam logic [1:0] DIS_LOW = 2'h0;
  localparam logic [1:0] DIS_HIGH = 2'h1;
  localparam logic [1:0] DIS_HIZ = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : led_drive_pkg
`default_nettype wire

// [led_duty_store.sv]
// per-channel duty value store with registered read port
`default_nettype none
module led_duty_store #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data,
  output logic [WIDTH*DEPTH-1:0] all_data
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_reg[i] <= '0;
      end
    end else if (wr_en) begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_data <= '0;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      all_data[i*WIDTH +: WIDTH] = mem_reg[i];
    end
  end
endmodule : led_duty_store
`default_nettype wire

// [led_drive_note_end.sv]
// intentionally empty compile unit
`default_nettype none
`default_nettype wire

// [led_load_model.sv]
// load model: external n-type driver stage behind every channel output pin
`default_nettype none
module led_load_model #(
  parameter int NUM_CH = 16
) (
  input wire logic clk_sys,
  input wire logic [NUM_CH-1:0] upper_on,
  input wire logic [NUM_CH-1:0] lower_on,
  output logic [NUM_CH-1:0] lamp_lit,
  output var int shorts
);
  timeunit 1ns;
  timeprecision 1ps;
  // pull-up supplies the high level whenever the low side is off
  assign lamp_lit = ~lower_on;
  initial shorts = 0;
  // both transistors on at once would short the supply
  always @(posedge clk_sys) begin
    if (|(upper_on & lower_on)) begin
      shorts <= shorts + 1;
    end
  end
endmodule : led_load_model
`default_nettype wire

// [tb.sv]
// testbench: register access, drive table, disabled states and pwm duty counts
`default_nettype none
`define CHK(what, exp, got) begin check_count++; if ((got) !== (exp)) begin mismatches++; \
  $display("CHECK FAILED %s exp %0h got %0h", what, exp, got); end end
module tb import led_drive_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NCH = 16;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic awvalid = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic wvalid = 1'b0;
  logic bready = 1'b1;
  logic [7:0] araddr = 8'h00;
  logic arvalid = 1'b0;
  logic rready = 1'b1;
  logic gate_n = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [NCH-1:0] upper_on, lower_on, lamp_lit;
  int shorts;
  int mismatches = 0;
  int check_count = 0;

  led_output_drive_pwm_mixer #(.NUM_CH(NCH), .BLINK_TICK_CYC(4)) led_output_drive_pwm_mixer_i (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .output_gate_n(gate_n), .upper_on(upper_on), .lower_on(lower_on));

  led_load_model #(.NUM_CH(NCH)) led_load_model_i (.clk_sys(clk_sys), .upper_on(upper_on),
    .lower_on(lower_on), .lamp_lit(lamp_lit), .shorts(shorts));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic final_report;
    if (mismatches == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report

  initial begin
    #1000000;
    mismatches++;
    final_report();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys);
      if (!aw_ok && awready) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk_sys); while (!bvalid);
    `CHK("bresp", er, bresp);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clk_sys); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys); while (!rvalid);
    `CHK("rdata", e, rdata);
    `CHK("rresp", er, rresp);
  endtask : rchk

  function automatic logic [31:0] mode(input logic [1:0] d, input logic t, input logic i,
      input logic b);
    return 32'(d) << MODE_DIS_LSB | 32'(t) << MODE_TOTEM_BIT | 32'(i) << MODE_INVERT_BIT
      | 32'(b) << MODE_BLINK_BIT;
  endfunction : mode

  task automatic ochk(input logic [NCH-1:0] el, input logic [NCH-1:0] eh);
    `CHK("lower_on", el, lower_on);
    `CHK("upper_on", eh, upper_on);
  endtask : ochk

  task automatic settle;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic cnt(input int ch, input int n, output int lo, output int up);
    lo = 0;
    up = 0;
    repeat (n) begin
      @(posedge clk_sys);
      lo += int'(lower_on[ch]);
      up += int'(upper_on[ch]);
    end
  endtask : cnt

  initial begin
    int lo;
    int up;
    int duty[3];
    logic [NCH-1:0] el;
    logic [NCH-1:0] eh;
    duty = '{0, 128, 255};
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    ochk({NCH{1'b1}}, '0);
    rchk(ADDR_MODE, 32'h0, RESP_OKAY);
    rchk(ADDR_GROUP_DUTY, 32'hff, RESP_OKAY);
    rchk(ADDR_GROUP_PERIOD, 32'h0, RESP_OKAY);
    rchk(ADDR_CHANNEL_STATE, 32'h0, RESP_OKAY);
    rchk(ADDR_DUTY_BASE, 32'h0, RESP_OKAY);
    rchk(ADDR_STATUS, 32'h3, RESP_OKAY);
    rchk(8'h20, 32'h0, RESP_SLVERR);
    wr(8'h20, 32'h1, RESP_SLVERR);
    wr(ADDR_DUTY_BASE + 8'h04, 32'ha5, RESP_OKAY);
    rchk(ADDR_DUTY_BASE + 8'h04, 32'ha5, RESP_OKAY);
    wr(ADDR_GROUP_PERIOD, 32'h3, RESP_OKAY);
    rchk(ADDR_GROUP_PERIOD, 32'h3, RESP_OKAY);
    wr(ADDR_GROUP_PERIOD, 32'h0, RESP_OKAY);
    // gate high: state on and invert must be ignored
    wr(ADDR_CHANNEL_STATE, 32'h5555_5555, RESP_OKAY);
    for (int d = 0; d < 4; d++) begin
      for (int t = 0; t < 2; t++) begin
        wr(ADDR_MODE, mode(2'(d), t[0], 1'b1, 1'b0), RESP_OKAY);
        settle();
        ochk((d == 0) ? {NCH{1'b1}} : '0, (d == 1 && t == 1) ? {NCH{1'b1}} : '0);
      end
    end
    gate_n <= 1'b0;
    for (int st = 0; st < 2; st++) begin
      wr(ADDR_CHANNEL_STATE, st ? 32'h5555_5555 : 32'h0, RESP_OKAY);
      for (int i = 0; i < 2; i++) begin
        for (int t = 0; t < 2; t++) begin
          wr(ADDR_MODE, mode(2'h0, t[0], i[0], 1'b0), RESP_OKAY);
          settle();
          el = {NCH{st[0] ^ i[0]}};
          eh = {NCH{~(st[0] ^ i[0]) & t[0]}};
          ochk(el, eh);
          `CHK("lamp_lit", ~el, lamp_lit);
        end
      end
    end
    wr(ADDR_MODE, mode(2'h0, 1'b1, 1'b0, 1'b0), RESP_OKAY);
    wr(ADDR_CHANNEL_STATE, 32'h0, RESP_OKAY);
    settle();
    wr(ADDR_CHANNEL_STATE, 32'h5555_5555, RESP_OKAY);
    #1;
    ochk({NCH{1'b1}}, '0);
    for (int c = 0; c < 3; c++) begin
      wr(ADDR_DUTY_BASE + 8'(4 * c), 32'(duty[c]), RESP_OKAY);
    end
    wr(ADDR_CHANNEL_STATE, 32'h0000_002a, RESP_OKAY);
    settle();
    for (int c = 0; c < 3; c++) begin
      cnt(c, 512, lo, up);
      `CHK("low side duty", duty[c] * 2, lo);
      `CHK("high side duty", 512 - duty[c] * 2, up);
    end
    // blink at period 0 spans 1024 cycles, half of it active
    wr(ADDR_MODE, mode(2'h0, 1'b0, 1'b0, 1'b1), RESP_OKAY);
    wr(ADDR_GROUP_DUTY, 32'h80, RESP_OKAY);
    wr(ADDR_DUTY_BASE, 32'hff, RESP_OKAY);
    wr(ADDR_CHANNEL_STATE, 32'h0000_0003, RESP_OKAY);
    settle();
    cnt(0, 1024, lo, up);
    `CHK("blink mixed duty", 510, lo);
    `CHK("open drain high side", 0, up);
    wr(ADDR_MODE, mode(2'h0, 1'b0, 1'b0, 1'b0), RESP_OKAY);
    wr(ADDR_GROUP_DUTY, 32'h0, RESP_OKAY);
    settle();
    cnt(0, 1024, lo, up);
    `CHK("dim mixed duty", 0, lo);
    `CHK("shoot through", 0, shorts);
    rchk(ADDR_STATUS, 32'h0, RESP_OKAY);
    final_report();
  end
endmodule : tb
`default_nettype wire
